// ### ifpd_defs.svh
`ifndef IFPD_DEFS_SVH
`define IFPD_DEFS_SVH
`define IFPD_CACHE_SETS 512
`define IFPD_TLB1_SMALL 16
`define IFPD_TLB1_LARGE 8
`define IFPD_TLB2_SETS 64
`define IFPD_TLB2_WAYS 4
`define IFPD_BTB_ENTRIES 2048
`define IFPD_RAS_DEPTH 12
`define IFPD_MISPRED_CYC 10
`define IFPD_PIPE_DEPTH 5
`define IFPD_SLOTS 3
`define IFPD_BLK_MAX 2'h3
`define IFPD_RESET_PC 32'h00000000
`define IFPD_CTR_RESET 2'h1
`define IFPD_ENC_LEN 1:0
`define IFPD_ENC_MC 2
`define IFPD_ENC_CLS 4:3
`define IFPD_ENC_TWO 5
`define IFPD_ENC_PFX 7
`define IFPD_CLS_CALL 2'h1
`define IFPD_CLS_RET 2'h2
`define IFPD_CLS_JMP 2'h3
`endif

// ### ifpd_far_end.sv
`timescale 1ns/10ps
`default_nettype none
module ifpd_far_end (
  // Clock, reset and pacing
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  // Line fill
  input wire logic fill_req_valid,
  input wire logic [25:0] fill_req_addr,
  input wire logic fill_req_bus,
  output logic fill_req_ready,
  output logic fill_rsp_valid,
  output logic fill_rsp_miss,
  output logic [511:0] fill_rsp_data,
  // Page walk
  input wire logic walk_req_valid,
  input wire logic [19:0] walk_req_vpn,
  output logic walk_rsp_valid,
  output logic [19:0] walk_rsp_ppn,
  output logic walk_rsp_large
);
  // Initialised so the design sees no unknown before reset lands
  logic rdy = 1'h0;
  logic rv = 1'h0;
  logic rm = 1'h0;
  logic [511:0] rd = '0;
  logic wv = 1'h0;
  logic [19:0] wp = 20'h0;
  logic wl = 1'h0;
  logic busy = 1'h0;
  logic b = 1'h0;
  logic [2:0] cnt = 3'h0;
  logic [25:0] a = 26'h0;
  logic [511:0] line;
  function automatic logic [7:0] mb(input logic [31:0] p);
    mb = p < 32'h1000 ? 8'h00 : (p[0] ? 8'h44 : 8'h04);
  endfunction : mb
  assign fill_req_ready = rdy;
  assign fill_rsp_valid = rv;
  assign fill_rsp_miss = rm;
  assign fill_rsp_data = rd;
  assign walk_rsp_valid = wv;
  assign walk_rsp_ppn = wp;
  assign walk_rsp_large = wl;
  always_comb begin
    for (int i = 0; i < 64; i++)
      line[8*i +: 8] = mb({a, 6'(i)});
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy <= 1'h0;
      rv <= 1'h0;
      wv <= 1'h0;
      busy <= 1'h0;
    end else begin
      rv <= 1'h0;
      wv <= 1'h0;
      // Idle lines toggle so stale data is never mistaken for a line
      rm <= ~rm;
      rd <= ~rd;
      wp <= ~wp;
      if (fill_req_valid && rdy) begin
        rdy <= 1'h0;
        busy <= 1'h1;
        a <= fill_req_addr;
        b <= fill_req_bus;
        cnt <= slow ? fill_req_addr[2:0] : 3'h0;
      end else if (busy && cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end else if (busy) begin
        busy <= 1'h0;
        rv <= 1'h1;
        rm <= !b && a[1];
        rd <= line;
      end else if (fill_req_valid) begin
        rdy <= 1'h1;
      end
      if (walk_req_valid && !wv) begin
        wv <= 1'h1;
        wp <= walk_req_vpn;
        // Odd pages come back large; identity map keeps addresses intact
        wl <= walk_req_vpn[0];
      end
    end
  end
endmodule : ifpd_far_end
`default_nettype wire

// ### ifpd_frontend.sv
`timescale 1ns/10ps
`default_nettype none
`include "ifpd_defs.svh"
module ifpd_frontend #(
  parameter int SETS = `IFPD_CACHE_SETS,
  parameter int BTBN = `IFPD_BTB_ENTRIES,
  parameter int RASN = `IFPD_RAS_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Line fill toward second-level cache or bus interface unit
  output logic fill_req_valid,
  input wire logic fill_req_ready,
  output logic [25:0] fill_req_addr,
  output logic fill_req_bus,
  input wire logic fill_rsp_valid,
  input wire logic fill_rsp_miss,
  input wire logic [511:0] fill_rsp_data,
  // Page walk for translation misses
  output logic walk_req_valid,
  output logic [19:0] walk_req_vpn,
  input wire logic walk_rsp_valid,
  input wire logic [19:0] walk_rsp_ppn,
  input wire logic walk_rsp_large,
  // Branch resolution from instruction control unit
  input wire logic res_valid,
  input wire ifpd_pkg::ifpd_resolve_t res,
  // Decoded bundles toward instruction control unit
  input wire logic out_ready,
  output logic [2:0] out_valid,
  output ifpd_pkg::ifpd_bundle_t [2:0] out_bundle
);
  localparam int SW = $clog2(SETS);
  localparam int BW = $clog2(BTBN);
  localparam int RW = $clog2(RASN);

  function automatic ifpd_pkg::ifpd_pdec_t predecode(
      input logic [511:0] d);
    ifpd_pkg::ifpd_pdec_t p;
    logic [7:0] b;
    logic [7:0] disp;
    int pos;
    int tgt;
    p = '0;
    pos = 0;
    for (int i = 0; i < 64; i++) begin
      b = d[i*8 +: 8];
      disp = d[((i + 1) % 64)*8 +: 8];
      if (i == pos) begin
        p.start[i] = 1'b1;
        p.opc[(b[`IFPD_ENC_PFX] && i < 63) ? i + 1 : i] = 1'b1;
        p.mc[i] = b[`IFPD_ENC_MC];
        p.call[i] = b[`IFPD_ENC_CLS] == `IFPD_CLS_CALL;
        p.ret[i] = b[`IFPD_ENC_CLS] == `IFPD_CLS_RET;
        pos = i + int'(b[`IFPD_ENC_LEN]) + 1;
        tgt = pos + int'($signed(disp));
        // Forward targets inside the line only; others continue at the fall-through byte
        if ((b[`IFPD_ENC_CLS] == `IFPD_CLS_CALL ||
             b[`IFPD_ENC_CLS] == `IFPD_CLS_JMP) && tgt > pos && tgt < 64)
          pos = tgt;
      end
    end
    return p;
  endfunction : predecode

  function automatic logic [3:0] first_idx(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (v[i]) r = 4'(i);
    return r;
  endfunction : first_idx

  // Microcode sequence store, a fixed table folded into logic
  function automatic logic [15:0] mc_store(input logic [7:0] op,
      input logic [2:0] step);
    return {op ^ {5'h00, step}, 5'h15, step};
  endfunction : mc_store

  function automatic ifpd_pkg::ifpd_bundle_t mk(
      input ifpd_pkg::ifpd_insn_t i, input logic [2:0] step,
      input logic last);
    ifpd_pkg::ifpd_bundle_t o;
    o.pc = i.pc;
    o.opcode = i.opcode;
    o.mcoded = i.mcode;
    o.step = step;
    o.last = last;
    o.micro = i.mcode ? mc_store(i.opcode, step)
                      : {7'h00, i.two_ops, i.opcode};
    return o;
  endfunction : mk

  ifpd_pkg::ifpd_fstate_t st;
  logic [31:0] pc;
  logic [3:0] pen;
  logic [19:0] tvpn;
  logic [25:0] faddr;
  logic fbus, fpf;
  // Storage arrays: instruction cache, translation, prediction
  logic [511:0] cdata [2][SETS];
  logic [25-SW:0] ctag [2][SETS];
  ifpd_pkg::ifpd_pdec_t cpd [2][SETS];
  logic [SETS-1:0] cval [2];
  logic [SETS-1:0] lru;
  logic [19:0] t1_vpn [16], t1_ppn [16];
  logic [9:0] t1l_vpn [8], t1l_ppn [8];
  logic [15:0] t1_v;
  logic [7:0] t1l_v;
  logic [3:0] t1p;
  logic [2:0] t1lp;
  logic [13:0] t2_tag [4][64];
  logic [19:0] t2_ppn [4][64];
  logic [63:0] t2_v [4];
  logic [1:0] t2p;
  logic [BTBN-1:0] btb_v;
  logic [27-BW:0] btb_tag [BTBN];
  logic [31:0] btb_tgt [BTBN];
  logic [BTBN-1:0][1:0] ctr;
  logic [BW-1:0] ghist;
  logic [31:0] ras [RASN];
  logic [RW-1:0] ras_top;
  logic [RW:0] ras_cnt;
  // Pipeline: scan, first_alignment_stage, align2, decode list, output
  ifpd_pkg::ifpd_win_t s1;
  ifpd_pkg::ifpd_list_t a1, a2, dl, scan;
  logic [2:0] dptr, mstep;

  // Translation lookup
  logic tlb_hit, t2_hit;
  logic [19:0] ppn, t2_hppn;
  always_comb begin
    tlb_hit = 1'b0;
    ppn = '0;
    t2_hit = 1'b0;
    t2_hppn = '0;
    for (int i = 0; i < `IFPD_TLB1_SMALL; i++)
      if (t1_v[i] && t1_vpn[i] == pc[31:12]) begin
        tlb_hit = 1'b1;
        ppn = t1_ppn[i];
      end
    for (int i = 0; i < `IFPD_TLB1_LARGE; i++)
      if (t1l_v[i] && t1l_vpn[i] == pc[31:22]) begin
        tlb_hit = 1'b1;
        ppn = {t1l_ppn[i], pc[21:12]};
      end
    for (int w = 0; w < `IFPD_TLB2_WAYS; w++)
      if (t2_v[w][tvpn[5:0]] && t2_tag[w][tvpn[5:0]] == tvpn[19:6]) begin
        t2_hit = 1'b1;
        t2_hppn = t2_ppn[w][tvpn[5:0]];
      end
  end

  // Cache and prediction read in the same access
  wire [31:0] paddr = {ppn, pc[11:0]};
  wire [SW-1:0] cset = paddr[6 +: SW];
  wire hit0 = cval[0][cset] && ctag[0][cset] == paddr[31:6+SW];
  wire hit1 = cval[1][cset] && ctag[1][cset] == paddr[31:6+SW];
  wire chit = tlb_hit && (hit0 || hit1);
  wire [511:0] line = hit1 ? cdata[1][cset] : cdata[0][cset];
  wire ifpd_pkg::ifpd_pdec_t lpd = hit1 ? cpd[1][cset] : cpd[0][cset];
  wire [15:0] lo_mask = 16'hFFFF << pc[3:0];
  wire [127:0] wbytes = line[pc[5:4]*128 +: 128];
  wire [15:0] wcall = lpd.call[pc[5:4]*16 +: 16] & lo_mask;
  wire [15:0] wret = lpd.ret[pc[5:4]*16 +: 16] & lo_mask;
  wire [BW-1:0] bidx = pc[4 +: BW];
  wire btb_hit = btb_v[bidx] && btb_tag[bidx] == pc[31:4+BW];
  wire take = btb_hit && ctr[bidx ^ ghist][1];
  wire ret_pop = |wret && ras_cnt != '0;
  wire [3:0] cidx = first_idx(wcall);
  wire [7:0] cbyte = wbytes[cidx*8 +: 8];
  wire [31:0] push_pc = {pc[31:4], cidx} + 32'(cbyte[`IFPD_ENC_LEN]) +
    32'h1;
  wire [31:0] seq_pc = {pc[31:4] + 28'h1, 4'h0};
  wire [31:0] pred_pc = ret_pop ? ras[ras_top] : take ? btb_tgt[bidx]
    : seq_pc;
  wire flush = res_valid && res.mispredict;

  // Decode stage: emits bundles from the held list
  logic [2:0] next_ov, next_dptr, next_mstep, mcnt, s, idx;
  ifpd_pkg::ifpd_bundle_t [2:0] next_ob;
  ifpd_pkg::ifpd_insn_t head;
  logic stop;
  wire otake = out_ready || !(|out_valid);
  always_comb begin
    next_ov = '0;
    next_ob = '0;
    next_dptr = dptr;
    next_mstep = mstep;
    stop = 1'b0;
    s = '0;
    idx = '0;
    head = dl.insn[dptr];
    mcnt = {1'b0, head.opcode[6:5]} + 3'h2;
    if (dptr < dl.cnt) begin
      if (head.mcode) begin
        // Microcoded head blocks direct decode this cycle
        for (int k = 0; k < `IFPD_SLOTS; k++) begin
          s = mstep + 3'(k);
          if (s < mcnt) begin
            next_ov[k] = 1'b1;
            next_ob[k] = mk(head, s, s == mcnt - 3'h1);
            next_mstep = s + 3'h1;
          end
        end
        if (next_mstep == mcnt) begin
          next_dptr = dptr + 3'h1;
          next_mstep = '0;
        end
      end else begin
        for (int k = 0; k < `IFPD_SLOTS; k++) begin
          idx = dptr + 3'(k);
          if (!stop && idx < dl.cnt && !dl.insn[idx].mcode) begin
            next_ov[k] = 1'b1;
            next_ob[k] = mk(dl.insn[idx], 3'h0, 1'b1);
            next_dptr = idx + 3'h1;
          end else
            stop = 1'b1;
        end
      end
    end
  end
  wire adv = (otake ? next_dptr : dptr) >= dl.cnt;

  // Scan: at most three per 8-byte half, one microcoded
  logic [1:0] hc0, hc1;
  logic mseen, cut, full;
  logic [31:0] cut_pc;
  logic [4:0] oi;
  always_comb begin
    scan = '0;
    cut = 1'b0;
    cut_pc = s1.pc;
    hc0 = '0;
    hc1 = '0;
    mseen = 1'b0;
    full = 1'b0;
    oi = '0;
    for (int b = 0; b < 16; b++) begin
      oi = (s1.opc[b] || b == 15) ? 5'(b) : 5'(b + 1);
      if (s1.valid && !cut && s1.start[b]) begin
        full = b[3] ? hc1 == `IFPD_BLK_MAX : hc0 == `IFPD_BLK_MAX;
        if (full || (s1.mc[b] && mseen)) begin
          cut = 1'b1;
          cut_pc = {s1.pc[31:4], 4'(b)};
        end else begin
          scan.insn[scan.cnt].pc = {s1.pc[31:4], 4'(b)};
          scan.insn[scan.cnt].opcode = s1.bytes[oi*8 +: 8];
          // Path follows microcode flag only, not length or op count
          scan.insn[scan.cnt].mcode = s1.mc[b];
          scan.insn[scan.cnt].two_ops = s1.bytes[b*8+`IFPD_ENC_TWO];
          scan.cnt = scan.cnt + 3'h1;
          if (b[3])
            hc1 = hc1 + 2'h1;
          else
            hc0 = hc0 + 2'h1;
          mseen = mseen | s1.mc[b];
        end
      end
    end
  end

  wire fetch_go = st == ifpd_pkg::FS_RUN && pen == '0 && adv;
  wire fetch_ok = fetch_go && chit && !cut;
  wire ifpd_pkg::ifpd_win_t win = '{1'b1, pc, wbytes,
    lpd.start[pc[5:4]*16 +: 16] & lo_mask | (16'h1 << pc[3:0]),
    lpd.opc[pc[5:4]*16 +: 16], lpd.mc[pc[5:4]*16 +: 16]};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= '0;
      a1 <= '0;
      a2 <= '0;
      dl <= '0;
      dptr <= '0;
      mstep <= '0;
      out_valid <= '0;
      out_bundle <= '0;
    end else if (flush) begin
      s1 <= '0;
      a1 <= '0;
      a2 <= '0;
      dl <= '0;
      dptr <= '0;
      mstep <= '0;
      out_valid <= '0;
    end else begin
      if (otake) begin
        out_valid <= next_ov;
        out_bundle <= next_ob;
        dptr <= next_dptr;
        mstep <= next_mstep;
      end
      if (adv) begin
        s1 <= fetch_ok ? win : '0;
        a1 <= scan;
        a2 <= a1;
        dl <= a2;
        dptr <= '0;
        mstep <= '0;
      end
    end
  end

  // Fetch pointer, penalty and return stack
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc <= `IFPD_RESET_PC;
      pen <= '0;
      ras_top <= '0;
      ras_cnt <= '0;
    end else if (flush) begin
      pc <= res.fix_addr;
      // Pipe depth supplies the rest of the penalty
      pen <= 4'(`IFPD_MISPRED_CYC - `IFPD_PIPE_DEPTH);
    end else if (pen != '0)
      pen <= pen - 4'h1;
    else if (adv && cut)
      pc <= cut_pc;
    else if (fetch_ok) begin
      pc <= pred_pc;
      if (ret_pop) begin
        ras_top <= ras_top == '0 ? RW'(RASN - 1) : ras_top - 1'b1;
        ras_cnt <= ras_cnt - 1'b1;
      end else if (|wcall) begin
        ras_top <= ras_top == RW'(RASN - 1) ? '0 : ras_top + 1'b1;
        if (ras_cnt != (RW+1)'(RASN))
          ras_cnt <= ras_cnt + 1'b1;
      end
    end
  end

  // Prediction training from resolved branches
  wire [BW-1:0] ridx = res.pc[4 +: BW];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      btb_v <= '0;
      ghist <= '0;
      ctr <= {BTBN{`IFPD_CTR_RESET}};
    end else if (res_valid) begin
      ghist <= {ghist[BW-2:0], res.taken};
      if (res.taken)
        btb_v[ridx] <= 1'b1;
      if (res.taken && ctr[ridx ^ ghist] != 2'h3)
        ctr[ridx ^ ghist] <= ctr[ridx ^ ghist] + 2'h1;
      else if (!res.taken && ctr[ridx ^ ghist] != 2'h0)
        ctr[ridx ^ ghist] <= ctr[ridx ^ ghist] - 2'h1;
    end
  end

  // Fill and translation-miss sequencer
  wire fill_done = st == ifpd_pkg::FS_WAIT && fill_rsp_valid &&
    (fbus || !fill_rsp_miss);
  wire [SW-1:0] fset = faddr[SW-1:0];
  wire vway = !cval[0][fset] ? 1'b0 : !cval[1][fset] ? 1'b1 : lru[fset];
  wire t1_load = (st == ifpd_pkg::FS_TLB && t2_hit) ||
    (st == ifpd_pkg::FS_WALK && walk_rsp_valid && !walk_rsp_large);
  wire [19:0] t1_new = st == ifpd_pkg::FS_TLB ? t2_hppn : walk_rsp_ppn;
  wire t2_load = st == ifpd_pkg::FS_WALK && walk_rsp_valid &&
    !walk_rsp_large;
  wire tl_load = st == ifpd_pkg::FS_WALK && walk_rsp_valid &&
    walk_rsp_large;
  assign fill_req_valid = st == ifpd_pkg::FS_REQ;
  assign fill_req_addr = faddr;
  assign fill_req_bus = fbus;
  assign walk_req_valid = st == ifpd_pkg::FS_WALK;
  assign walk_req_vpn = tvpn;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= ifpd_pkg::FS_RUN;
      tvpn <= '0;
      faddr <= '0;
      fbus <= 1'b0;
      fpf <= 1'b0;
    end else begin
      unique case (st)
        ifpd_pkg::FS_RUN:
          if (fetch_go && !tlb_hit) begin
            st <= ifpd_pkg::FS_TLB;
            tvpn <= pc[31:12];
          end else if (fetch_go && !chit) begin
            st <= ifpd_pkg::FS_REQ;
            faddr <= paddr[31:6];
            fbus <= 1'b0;
            fpf <= 1'b0;
          end
        ifpd_pkg::FS_TLB:
          st <= t2_hit ? ifpd_pkg::FS_RUN : ifpd_pkg::FS_WALK;
        ifpd_pkg::FS_WALK:
          if (walk_rsp_valid)
            st <= ifpd_pkg::FS_RUN;
        ifpd_pkg::FS_REQ:
          if (fill_req_ready)
            st <= ifpd_pkg::FS_WAIT;
        ifpd_pkg::FS_WAIT:
          if (fill_rsp_valid && fill_rsp_miss && !fbus) begin
            fbus <= 1'b1;
            st <= ifpd_pkg::FS_REQ;
          end else if (fill_done && !fpf) begin
            fpf <= 1'b1;
            fbus <= 1'b0;
            faddr <= faddr + 26'h1;
            st <= ifpd_pkg::FS_REQ;
          end else if (fill_done)
            st <= ifpd_pkg::FS_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cval[0] <= '0;
      cval[1] <= '0;
      lru <= '0;
      t1_v <= '0;
      t1l_v <= '0;
      t1p <= '0;
      t1lp <= '0;
      t2p <= '0;
      for (int w = 0; w < `IFPD_TLB2_WAYS; w++)
        t2_v[w] <= '0;
    end else begin
      if (fill_done) begin
        cval[vway][fset] <= 1'b1;
        lru[fset] <= ~vway;
      end else if (fetch_ok)
        lru[cset] <= ~hit1;
      if (t1_load) begin
        t1_v[t1p] <= 1'b1;
        t1p <= t1p + 4'h1;
      end
      if (tl_load) begin
        t1l_v[t1lp] <= 1'b1;
        t1lp <= t1lp + 3'h1;
      end
      if (t2_load) begin
        t2_v[t2p][tvpn[5:0]] <= 1'b1;
        t2p <= t2p + 2'h1;
      end
    end
  end

  // Array contents carry no reset; valid bits guard them
  always_ff @(posedge clk) begin
    if (fill_done) begin
      cdata[vway][fset] <= fill_rsp_data;
      ctag[vway][fset] <= faddr[25:SW];
      cpd[vway][fset] <= predecode(fill_rsp_data);
    end
    if (t1_load) begin
      t1_vpn[t1p] <= tvpn;
      t1_ppn[t1p] <= t1_new;
    end
    if (tl_load) begin
      t1l_vpn[t1lp] <= tvpn[19:10];
      t1l_ppn[t1lp] <= walk_rsp_ppn[19:10];
    end
    if (t2_load) begin
      t2_tag[t2p][tvpn[5:0]] <= tvpn[19:6];
      t2_ppn[t2p][tvpn[5:0]] <= walk_rsp_ppn;
    end
    if (res_valid && res.taken) begin
      btb_tag[ridx] <= res.pc[31:4+BW];
      btb_tgt[ridx] <= res.target;
    end
    if (!flush && pen == '0 && !(adv && cut) && fetch_ok && !ret_pop &&
        |wcall)
      ras[ras_top == RW'(RASN - 1) ? '0 : ras_top + 1'b1] <= push_pc;
  end
endmodule : ifpd_frontend
`default_nettype wire

// ### ifpd_frontend_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "ifpd_defs.svh"
module ifpd_frontend_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Line fill
  input wire logic fill_req_valid,
  input wire logic fill_req_ready,
  input wire logic [25:0] fill_req_addr,
  input wire logic fill_req_bus,
  input wire logic fill_rsp_valid,
  input wire logic fill_rsp_miss,
  // Page walk
  input wire logic walk_req_valid,
  input wire logic [19:0] walk_req_vpn,
  input wire logic walk_rsp_valid,
  // Resolution and bundles
  input wire logic res_valid,
  input wire ifpd_pkg::ifpd_resolve_t res,
  input wire logic out_ready,
  input wire logic [2:0] out_valid,
  input wire ifpd_pkg::ifpd_bundle_t [2:0] out_bundle
);
  logic [25:0] acc_addr;
  logic acc_bus;
  logic took;
  logic flush;
  logic [3:0] quiet;
  assign took = fill_req_valid && fill_req_ready;
  // Counts the silent cycles owed after a redirect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      quiet <= 4'h0;
    else if (flush)
      quiet <= 4'(`IFPD_MISPRED_CYC);
    else if (quiet != 4'h0)
      quiet <= quiet - 4'h1;
  end
  assign flush = res_valid && res.mispredict;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_addr <= 26'h0;
      acc_bus <= 1'h0;
    end else if (took) begin
      acc_addr <= fill_req_addr;
      acc_bus <= fill_req_bus;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  stall_hold_a: assert property (out_valid != 3'h0 && !out_ready && !flush
    |=> $stable(out_valid) && $stable(out_bundle))
    else $error("bundles moved while refused");
  flush_quiet_a: assert property (quiet != 4'h0
    |-> out_valid == 3'h0)
    else $error("bundles too soon after redirect");
  slot_pack_a: assert property (out_valid inside {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("slots not packed from zero");
  miss_retry_a: assert property (fill_rsp_valid && fill_rsp_miss && !acc_bus
    |-> ##[1:8] fill_req_valid && fill_req_bus && fill_req_addr == acc_addr)
    else $error("no bus retry after cache miss");
  req_hold_a: assert property (fill_req_valid && !fill_req_ready
    |=> fill_req_valid && $stable(fill_req_addr) && $stable(fill_req_bus))
    else $error("fill request changed before accept");
  mc_alone_a: assert property (out_valid[1] && out_bundle[0].mcoded
    |-> out_bundle[1].mcoded && out_bundle[1].pc == out_bundle[0].pc)
    else $error("microcoded bundle shares its cycle");
  step_order_a: assert property (out_valid[1] && out_bundle[1].mcoded
    |-> out_bundle[1].step == out_bundle[0].step + 3'h1)
    else $error("microcode steps out of order");
  walk_hold_a: assert property (walk_req_valid && !walk_rsp_valid
    |=> walk_req_valid && $stable(walk_req_vpn))
    else $error("walk request dropped early");
endmodule : ifpd_frontend_checker
bind ifpd_frontend ifpd_frontend_checker i_ifpd_frontend_checker (
  .clk(clk), .resetn(resetn), .fill_req_valid(fill_req_valid),
  .fill_req_ready(fill_req_ready), .fill_req_addr(fill_req_addr),
  .fill_req_bus(fill_req_bus), .fill_rsp_valid(fill_rsp_valid),
  .fill_rsp_miss(fill_rsp_miss), .walk_req_valid(walk_req_valid),
  .walk_req_vpn(walk_req_vpn), .walk_rsp_valid(walk_rsp_valid),
  .res_valid(res_valid), .res(res), .out_ready(out_ready),
  .out_valid(out_valid), .out_bundle(out_bundle));
`default_nettype wire

// ### ifpd_pkg.sv
package ifpd_pkg;
  typedef struct packed {
    logic [31:0] pc;
    logic [7:0] opcode;
    logic mcode;
    logic two_ops;
  } ifpd_insn_t;
  typedef struct packed {
    logic [2:0] cnt;
    ifpd_insn_t [7:0] insn;
  } ifpd_list_t;
  typedef struct packed {
    logic [31:0] pc;
    logic [7:0] opcode;
    logic mcoded;
    logic [2:0] step;
    logic last;
    logic [15:0] micro;
  } ifpd_bundle_t;
  typedef struct packed {
    logic mispredict;
    logic taken;
    logic [31:0] pc;
    logic [31:0] target;
    logic [31:0] fix_addr;
  } ifpd_resolve_t;
  typedef struct packed {
    logic [63:0] start, opc, mc, call, ret;
  } ifpd_pdec_t;
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [127:0] bytes;
    logic [15:0] start, opc, mc;
  } ifpd_win_t;
  typedef enum logic [2:0] {FS_RUN, FS_TLB, FS_WALK, FS_REQ, FS_WAIT}
    ifpd_fstate_t;
endpackage : ifpd_pkg

// ### tb_instruction_fetch_predecode_frontend.sv
`timescale 1ns/10ps
`default_nettype none
module tb_instruction_fetch_predecode_frontend;
  logic clk, resetn, slow, out_ready, res_valid;
  logic fill_req_valid, fill_req_ready, fill_req_bus;
  logic fill_rsp_valid, fill_rsp_miss;
  logic [25:0] fill_req_addr;
  logic [511:0] fill_rsp_data;
  logic walk_req_valid, walk_rsp_valid, walk_rsp_large;
  logic [19:0] walk_req_vpn, walk_rsp_ppn;
  logic [2:0] out_valid;
  ifpd_pkg::ifpd_resolve_t res;
  ifpd_pkg::ifpd_bundle_t [2:0] out_bundle;
  int miscompares, comparisons, seed, got;
  logic [44:0] expq[$];
  logic [31:0] mpc;
  logic [25:0] la, pf_a;
  logic lb, want_pf, in_pf;
  ifpd_frontend i_ifpd_frontend (.clk(clk), .resetn(resetn),
    .fill_req_valid(fill_req_valid), .fill_req_ready(fill_req_ready),
    .fill_req_addr(fill_req_addr), .fill_req_bus(fill_req_bus),
    .fill_rsp_valid(fill_rsp_valid), .fill_rsp_miss(fill_rsp_miss),
    .fill_rsp_data(fill_rsp_data), .walk_req_valid(walk_req_valid),
    .walk_req_vpn(walk_req_vpn), .walk_rsp_valid(walk_rsp_valid),
    .walk_rsp_ppn(walk_rsp_ppn), .walk_rsp_large(walk_rsp_large),
    .res_valid(res_valid), .res(res), .out_ready(out_ready),
    .out_valid(out_valid), .out_bundle(out_bundle));
  ifpd_far_end i_ifpd_far_end (.clk(clk), .resetn(resetn), .slow(slow),
    .fill_req_valid(fill_req_valid), .fill_req_addr(fill_req_addr),
    .fill_req_bus(fill_req_bus), .fill_req_ready(fill_req_ready),
    .fill_rsp_valid(fill_rsp_valid), .fill_rsp_miss(fill_rsp_miss),
    .fill_rsp_data(fill_rsp_data), .walk_req_valid(walk_req_valid),
    .walk_req_vpn(walk_req_vpn), .walk_rsp_valid(walk_rsp_valid),
    .walk_rsp_ppn(walk_rsp_ppn), .walk_rsp_large(walk_rsp_large));
  function automatic logic [7:0] mb(input logic [31:0] p);
    mb = p < 32'h1000 ? 8'h00 : (p[0] ? 8'h44 : 8'h04);
  endfunction : mb
  task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Reference stream: one entry per bundle, microcode steps expanded
  task automatic gen();
    logic [7:0] b;
    int n;
    b = mb(mpc);
    n = b[2] ? b[6:5] + 2 : 1;
    for (int s = 0; s < n; s++)
      expq.push_back({mpc, b, b[2], 3'(s), s == n - 1});
    mpc = mpc + 32'(b[1:0]) + 32'h1;
  endtask : gen
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic run(input int want, input int t);
    int k;
    k = 0;
    while (got < want && k < 5000) begin
      @(posedge clk);
      out_ready <= 1'($random(seed));
      k++;
    end
    chk(44'(got >= want), 44'h1);
    $display("test %0d done", t);
  endtask : run
  // Consumer held off so no bundle is taken in the redirect cycle
  task automatic redirect(input logic [31:0] fa);
    @(posedge clk);
    out_ready <= 1'h0;
    res_valid <= 1'h1;
    res <= '{mispredict: 1'h1, taken: 1'h1, pc: mpc, target: fa,
             fix_addr: fa};
    @(posedge clk);
    res_valid <= 1'h0;
  endtask : redirect
  always @(posedge clk) begin
    logic [44:0] e;
    if (resetn && res_valid && res.mispredict) begin
      expq.delete();
      mpc = res.fix_addr;
    end else if (resetn && out_ready) begin
      for (int i = 0; i < 3; i++)
        if (out_valid[i]) begin
          while (expq.size() < 8)
            gen();
          e = expq.pop_front();
          chk({out_bundle[i].pc, out_bundle[i].opcode, out_bundle[i].mcoded,
               out_bundle[i].step}, e[44:1]);
          chk({43'h0, out_bundle[i].last}, {43'h0, e[0]});
          if (!e[4])
            chk({28'h0, out_bundle[i].micro}, {35'h0, e[10], e[12:5]});
          got++;
        end
    end
    if (resetn && fill_req_valid && fill_req_ready) begin
      if (want_pf) begin
        chk({17'h0, fill_req_addr, fill_req_bus}, {17'h0, pf_a, 1'h0});
        in_pf = 1'h1;
        want_pf = 1'h0;
      end
      la = fill_req_addr;
      lb = fill_req_bus;
    end
    if (resetn && fill_rsp_valid && !(fill_rsp_miss && !lb)) begin
      if (!in_pf) begin
        want_pf = 1'h1;
        pf_a = la + 26'h1;
      end
      in_pf = 1'h0;
    end
  end
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(20000 * 100);
    miscompares++;
    report_and_stop();
  end
  initial begin
    seed = 53100;
    resetn = 1'h0;
    slow = 1'h0;
    out_ready = 1'h0;
    res_valid = 1'h0;
    res = '0;
    {miscompares, comparisons, got} = '0;
    {mpc, la, pf_a, lb, want_pf, in_pf} = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    run(60, 1);
    slow <= 1'h1;
    redirect(32'h00001000);
    run(got + 20, 2);
    redirect(32'h00000030);
    run(got + 40, 3);
    redirect(32'h00001001);
    run(got + 20, 4);
    report_and_stop();
  end
endmodule : tb_instruction_fetch_predecode_frontend
`default_nettype wire
